/* design/rvc_pkg.sv */
// rvc_pkg: shared types and constants of the thermometer value range coder
package rvc_pkg;

  // register byte offsets
  localparam logic [7:0] RVC_OFS_CTRL = 8'h00;
  localparam logic [7:0] RVC_OFS_VALUE = 8'h04;
  localparam logic [7:0] RVC_OFS_STATUS = 8'h08;
  localparam logic [7:0] RVC_OFS_MASK = 8'h0C;
  localparam logic [7:0] RVC_OFS_DIAG = 8'h10;

  // control field layout
  localparam int RVC_CTRL_CHAR_LSB = 0;
  localparam int RVC_CTRL_UNIT_LSB = 2;
  localparam int RVC_CTRL_WB_EN = 4;
  localparam int RVC_CTRL_OU_EN = 5;
  localparam logic [5:0] RVC_CTRL_RESET = 6'h00;

  // value register layout
  localparam int RVC_VAL_RANGE_LSB = 16;
  localparam int RVC_VAL_WB = 19;

  // diagnostic record layout
  localparam int RVC_DIAG_CNT_LSB = 8;

  // status / mask bit positions
  localparam int RVC_EV_WIRE_BREAK = 0;
  localparam int RVC_EV_HIGH_LIMIT = 1;
  localparam int RVC_EV_LOW_LIMIT = 2;
  localparam int RVC_EV_W = 3;

  // selection codes
  localparam logic [1:0] RVC_CHAR_PT_CLIMATE = 2'h0;
  localparam logic [1:0] RVC_CHAR_NI_STD = 2'h1;
  localparam logic [1:0] RVC_CHAR_NI_CLIMATE = 2'h2;
  localparam logic [1:0] RVC_UNIT_C = 2'h0;
  localparam logic [1:0] RVC_UNIT_F = 2'h1;
  localparam logic [1:0] RVC_UNIT_K = 2'h2;

  // saturation codes
  localparam logic [15:0] RVC_CODE_OVERFLOW = 16'h7FFF;
  localparam logic [15:0] RVC_CODE_UNDERFLOW = 16'h8000;

  typedef enum logic [2:0] {
    RVC_NOMINAL,
    RVC_OVERRANGE,
    RVC_UNDERRANGE,
    RVC_OVERFLOW,
    RVC_UNDERFLOW
  } rvc_range_t;

  typedef struct packed {
    logic signed [31:0] ovr_max;
    logic signed [31:0] nom_max;
    logic signed [31:0] nom_min;
    logic signed [31:0] und_min;
  } rvc_limits_t;

  typedef struct packed {
    logic valid;
    logic signed [31:0] value;
    logic open_circuit;
  } rvc_sample_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
    rvc_range_t range;
    logic wire_break;
  } rvc_coded_t;

endpackage

/* design/rvc_limit_lut.sv */
// rvc_limit_lut: range limits per thermometer characteristic and unit
`timescale 1ns/1ps
`default_nettype none
module rvc_limit_lut (
  // selection
  input wire logic [1:0] CHAR_SEL,
  input wire logic [1:0] UNIT_SEL,
  // limits
  output var rvc_pkg::rvc_limits_t LIMITS
);
  import rvc_pkg::*;

  function automatic rvc_limits_t mk(input int omax, input int nmax, input int nmin, input int umin);
    rvc_limits_t l;
    l.ovr_max = omax;
    l.nom_max = nmax;
    l.nom_min = nmin;
    l.und_min = umin;
    return l;
  endfunction

  // kelvin is only defined for the nickel standard curve; the climate curves fall back to celsius
  always_comb begin
    LIMITS = mk(15500, 13000, -12000, -14500); // R1
    unique case (CHAR_SEL)
      RVC_CHAR_PT_CLIMATE: begin
        if (UNIT_SEL == RVC_UNIT_F) begin
          LIMITS = mk(31100, 26600, -18400, -22900); // R1
        end
      end
      RVC_CHAR_NI_STD: begin
        if (UNIT_SEL == RVC_UNIT_F) begin
          LIMITS = mk(5630, 4820, -760, -1570); // R2
        end else if (UNIT_SEL == RVC_UNIT_K) begin
          LIMITS = mk(5682, 5232, 2132, 1682); // R2
        end else begin
          LIMITS = mk(2950, 2500, -600, -1050); // R2
        end
      end
      RVC_CHAR_NI_CLIMATE: begin
        if (UNIT_SEL == RVC_UNIT_F) begin
          LIMITS = mk(31100, 26600, -7600, -15700); // R3
        end else begin
          LIMITS = mk(15500, 13000, -6000, -10500); // R3
        end
      end
      default: begin
        // unused characteristic code keeps the platinum climate celsius limits
        LIMITS = mk(15500, 13000, -12000, -14500);
      end
    endcase
  end

endmodule
`default_nettype wire

/* design/rvc_coder.sv */
// rvc_coder: thermometer reading coder with diagnostics and avalon-mm registers
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Platinum climate: 0.01 degree digits, limits 13000/15500/-12000/-14500 C, F analog.
// R2 - Nickel standard: 0.1 degree digits, C, F and K limit sets.
// R3 - Nickel climate: 0.01 degree digits, C and F limit sets.
// R4 - Above overrange outputs 7FFF, below underrange outputs 8000, every curve.
// R5 - Enabled diagnostics create a diagnostic record entry and raise an interrupt.
// R6 - Enabled wire break outranks overflow/underflow diagnostics.
// R7 - Open circuit with wire break enabled outputs 7FFF and flags wire break.
// R8 - Wire break off, limits on: open circuit gives 8000 and low-limit alarm.
// R9 - Both diagnostics off: open circuit gives 8000, no alarm.
// R10 - Each coded value carries a nominal/over/under/overflow/underflow range indication.
module rvc_coder (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // digitized sensor reading, same clock domain
  input wire logic SMP_VALID,
  input wire logic signed [31:0] SMP_VALUE,
  input wire logic SMP_OPEN,
  // coded measured value
  output logic CODE_VALID,
  output logic [15:0] CODE_VALUE,
  output logic [2:0] CODE_RANGE,
  output logic CODE_WIRE_BREAK,
  // interrupt
  output logic IRQ
);
  import rvc_pkg::*;

  logic [5:0] ctrl;
  logic [RVC_EV_W-1:0] status;
  logic [RVC_EV_W-1:0] mask;
  logic [RVC_EV_W-1:0] diag_code;
  logic [7:0] diag_count;
  logic ack;
  rvc_limits_t limits;
  rvc_sample_t smp;
  rvc_coded_t coded;
  rvc_coded_t next_coded;
  logic [RVC_EV_W-1:0] next_event;
  logic wb_en;
  logic ou_en;
  logic wr_ok;
  logic [RVC_EV_W-1:0] status_clr;

  assign smp.valid = SMP_VALID;
  assign smp.value = SMP_VALUE;
  assign smp.open_circuit = SMP_OPEN;
  assign wb_en = ctrl[RVC_CTRL_WB_EN];
  assign ou_en = ctrl[RVC_CTRL_OU_EN];

  rvc_limit_lut u_lut (
    .CHAR_SEL(ctrl[RVC_CTRL_CHAR_LSB +: 2]),
    .UNIT_SEL(ctrl[RVC_CTRL_UNIT_LSB +: 2]),
    .LIMITS(limits)
  );

  // classification and diagnostic event selection
  always_comb begin
    next_coded.valid = smp.valid;
    next_coded.wire_break = 1'b0;
    next_coded.value = smp.value[15:0];
    next_coded.range = RVC_NOMINAL;
    next_event = '0;
    if (smp.open_circuit) begin
      if (wb_en) begin
        // wire break wins whatever the limit enable says
        next_coded.value = RVC_CODE_OVERFLOW; // R7
        next_coded.range = RVC_OVERFLOW;
        next_coded.wire_break = 1'b1;
        next_event[RVC_EV_WIRE_BREAK] = 1'b1; // R6
      end else begin
        next_coded.value = RVC_CODE_UNDERFLOW; // R8 R9
        next_coded.range = RVC_UNDERFLOW;
        next_event[RVC_EV_LOW_LIMIT] = ou_en; // R8 R9
      end
    end else if (smp.value > limits.ovr_max) begin
      next_coded.value = RVC_CODE_OVERFLOW; // R4
      next_coded.range = RVC_OVERFLOW; // R10
      next_event[RVC_EV_HIGH_LIMIT] = ou_en; // R5
    end else if (smp.value > limits.nom_max) begin
      next_coded.range = RVC_OVERRANGE; // R10
    end else if (smp.value >= limits.nom_min) begin
      next_coded.range = RVC_NOMINAL; // R10
    end else if (smp.value >= limits.und_min) begin
      next_coded.range = RVC_UNDERRANGE; // R10
    end else begin
      next_coded.value = RVC_CODE_UNDERFLOW; // R4
      next_coded.range = RVC_UNDERFLOW; // R10
      next_event[RVC_EV_LOW_LIMIT] = ou_en; // R5
    end
    if (!smp.valid) begin
      next_event = '0;
    end
  end

  // coded output register, holds last value between samples
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      coded.valid <= 1'b0;
      coded.value <= '0;
      coded.range <= RVC_NOMINAL;
      coded.wire_break <= 1'b0;
    end else begin
      coded.valid <= next_coded.valid;
      if (next_coded.valid) begin
        coded.value <= next_coded.value;
        coded.range <= next_coded.range;
        coded.wire_break <= next_coded.wire_break;
      end
    end
  end

  assign CODE_VALID = coded.valid;
  assign CODE_VALUE = coded.value;
  assign CODE_RANGE = coded.range;
  assign CODE_WIRE_BREAK = coded.wire_break;

  // one wait cycle per access: the request completes at its second edge
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ || AVS_WRITE) && !ack;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
  assign wr_ok = AVS_WRITE && !ack;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= RVC_CTRL_RESET;
    end else if (wr_ok && AVS_ADDRESS == RVC_OFS_CTRL && AVS_BYTEENABLE[0]) begin
      ctrl <= AVS_WRITEDATA[5:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask <= '0;
    end else if (wr_ok && AVS_ADDRESS == RVC_OFS_MASK && AVS_BYTEENABLE[0]) begin
      mask <= AVS_WRITEDATA[RVC_EV_W-1:0];
    end
  end

  // write-one-to-clear; a simultaneous event keeps its bit set
  assign status_clr = (wr_ok && AVS_ADDRESS == RVC_OFS_STATUS && AVS_BYTEENABLE[0]) ?
                      AVS_WRITEDATA[RVC_EV_W-1:0] : '0;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= '0;
    end else begin
      status <= (status & ~status_clr) | next_event; // R5
    end
  end

  // diagnostic record: last event code and a wrapping entry count
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      diag_code <= '0;
      diag_count <= '0;
    end else if (|next_event) begin
      diag_code <= next_event; // R5
      diag_count <= diag_count + 8'h01;
    end
  end

  assign IRQ = |(status & mask); // R5

  // read data is loaded in the wait cycle and stands at the completing edge
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ && !ack) begin
      AVS_READDATA <= '0;
      unique case (AVS_ADDRESS)
        RVC_OFS_CTRL: AVS_READDATA[5:0] <= ctrl;
        RVC_OFS_VALUE: begin
          AVS_READDATA[15:0] <= coded.value;
          AVS_READDATA[RVC_VAL_RANGE_LSB +: 3] <= coded.range;
          AVS_READDATA[RVC_VAL_WB] <= coded.wire_break;
        end
        RVC_OFS_STATUS: AVS_READDATA[RVC_EV_W-1:0] <= status;
        RVC_OFS_MASK: AVS_READDATA[RVC_EV_W-1:0] <= mask;
        RVC_OFS_DIAG: begin
          AVS_READDATA[RVC_EV_W-1:0] <= diag_code;
          AVS_READDATA[RVC_DIAG_CNT_LSB +: 8] <= diag_count;
        end
        default: AVS_READDATA <= '0;
      endcase
    end
  end

endmodule
`default_nettype wire

/* verif/rvc_coder_sva.sv */
// rvc_coder_sva: port checks of the coder
`timescale 1ns/1ps
`default_nettype none
module rvc_coder_sva (
  // watched ports
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic SMP_VALID,
  input wire logic signed [31:0] SMP_VALUE,
  input wire logic SMP_OPEN,
  input wire logic CODE_VALID,
  input wire logic [15:0] CODE_VALUE,
  input wire logic [2:0] CODE_RANGE,
  input wire logic CODE_WIRE_BREAK
);
  logic smp;
  logic [15:0] smp_low;
  assign smp = SMP_VALID && !SMP_OPEN;
  assign smp_low = SMP_VALUE[15:0];
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  a_code_late:
    assert property (SMP_VALID |=> CODE_VALID) else $error("code late");
  a_code_held:
    assert property (!SMP_VALID |=> !CODE_VALID && $stable(CODE_VALUE) && $stable(CODE_RANGE)) else $error("moved");
  a_open_code:
    assert property (SMP_VALID && SMP_OPEN |=> CODE_VALUE == (CODE_WIRE_BREAK ? 16'h7FFF : 16'h8000)) else $error("open");
  a_far_over:
    assert property (smp && SMP_VALUE > 31100 |=> CODE_VALUE == 16'h7FFF && CODE_RANGE == 3'h3) else $error("over");
  a_far_under:
    assert property (smp && SMP_VALUE < -22900 |=> CODE_VALUE == 16'h8000 && CODE_RANGE == 3'h4) else $error("under");
  a_nominal_pass:
    assert property (smp && SMP_VALUE inside {[2132:2500]} |=> CODE_VALUE == $past(smp_low) && CODE_RANGE == 3'h0)
      else $error("nominal");
  a_sat_range:
    assert property (CODE_VALID |-> (CODE_RANGE == 3'h3) == (CODE_VALUE == 16'h7FFF)) else $error("range");
  a_wb_code:
    assert property (CODE_WIRE_BREAK |-> CODE_VALUE == 16'h7FFF && CODE_RANGE == 3'h3) else $error("break");
  c_wire_break: cover property (CODE_VALID && CODE_WIRE_BREAK);
  c_overrange: cover property (CODE_VALID && CODE_RANGE == 3'h1);
  c_underflow: cover property (CODE_VALID && CODE_RANGE == 3'h4);
endmodule
bind rvc_coder rvc_coder_sva u_sva (.SYS_CLK, .ARST_N, .SMP_VALID, .SMP_VALUE, .SMP_OPEN, .CODE_VALID,
  .CODE_VALUE, .CODE_RANGE, .CODE_WIRE_BREAK);
`default_nettype wire

/* verif/rvc_sensor_model.sv */
// rvc_sensor_model: thermometer front end feeding readings
`timescale 1ns/1ps
`default_nettype none
module rvc_sensor_model (
  // clock
  input wire logic clk,
  // reading
  output logic smp_valid,
  output logic signed [31:0] smp_value,
  output logic smp_open
);
  initial begin
    smp_valid = 1'b0;
    smp_value = 32'h0;
    smp_open = 1'b0;
  end
  // lines flip once the strobe drops, so stale data never looks valid
  task automatic emit(input logic signed [31:0] v, input logic o, input int g);
    repeat (g) @(posedge clk);
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_value <= v;
    smp_open <= o;
    @(posedge clk);
    smp_valid <= 1'b0;
    smp_value <= ~v;
    smp_open <= ~o;
  endtask
endmodule
`default_nettype wire

/* verif/rvc_coder_tb_top.sv */
// rvc_coder_tb_top: directed tests of the coder
`timescale 1ns/1ps
`default_nettype none
module rvc_coder_tb_top;
  logic clk, rst_n, rd, wr, wreq, irq, sv, so, cv, cw;
  logic [7:0] adr;
  logic [31:0] wd, rdat, q;
  logic signed [31:0] sval;
  logic [15:0] cval;
  logic [2:0] crng;
  int fail_count, n_tests;
  int lim[7][4] = '{'{15500, 13000, -12000, -14500}, '{31100, 26600, -18400, -22900}, '{2950, 2500, -600, -1050},
    '{5630, 4820, -760, -1570}, '{5682, 5232, 2132, 1682}, '{15500, 13000, -6000, -10500}, '{31100, 26600, -7600, -15700}};
  logic [5:0] cfg[7] = '{6'h20, 6'h24, 6'h21, 6'h25, 6'h29, 6'h22, 6'h26};
  int bi[8] = '{1, 1, 0, 0, 2, 2, 3, 3};
  int dl[8] = '{0, 1, 0, 1, 0, -1, 0, -1};
  int rg[8] = '{0, 1, 1, 3, 0, 2, 2, 4};
  logic [5:0] en[4] = '{6'h30, 6'h10, 6'h20, 6'h00};
  logic [2:0] st[4] = '{3'h1, 3'h1, 3'h4, 3'h0};
  rvc_sensor_model fe (.clk(clk), .smp_valid(sv), .smp_value(sval), .smp_open(so));
  rvc_coder uut (.SYS_CLK(clk), .ARST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .SMP_VALID(sv), .SMP_VALUE(sval),
    .SMP_OPEN(so), .CODE_VALID(cv), .CODE_VALUE(cval), .CODE_RANGE(crng), .CODE_WIRE_BREAK(cw), .IRQ(irq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 64);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 64) chk(0, 1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic smp(input logic signed [31:0] v, input logic o, input logic [2:0] r, input logic w, input int g);
    fe.emit(v, o, g);
    #1;
    chk({cv, cw, crng, cval}, {1'b1, w, r, r == 3'h3 ? 16'h7FFF : r == 3'h4 ? 16'h8000 : v[15:0]});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h0);
    rchk(8'h0C, 32'h0);
    rchk(8'h14, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 8'h00, {26'h0, cfg[i]});
      for (int j = 0; j < 8; j++) smp(lim[i][bi[j]] + dl[j], 1'b0, rg[j], 1'b0, j);
    end
    $display("test limits done");
    rchk(8'h08, 32'h6);
    rchk(8'h10, 32'hE04);
    bus(1'b1, 8'h0C, 32'h2);
    #1 chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h08, 32'h6);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    bus(1'b1, 8'h0C, 32'h7);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'h08, 32'h7);
      bus(1'b1, 8'h00, {26'h0, en[k]});
      smp(32'sd100, 1'b1, en[k][4] ? 3'h3 : 3'h4, en[k][4], k);
      rchk(8'h08, {29'h0, st[k]});
      chk({31'h0, irq}, {31'h0, st[k] != 3'h0});
    end
    rchk(8'h04, 32'h48000);
    $display("test open circuit done");
    conclude();
  end
endmodule
`default_nettype wire
